// ### rtl/seq_map.svh
// Constants of the record transfer sequencer: packet ids, command codes, counts.
// Assumes the link layer below delivers whole packets with the id already split off.
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// Packet ids (values are plain defaults, set per product)
`define SEQ_PID_CMD_DATA   8'h0a
`define SEQ_PID_RECORDS    8'h1b
`define SEQ_PID_XFER_DONE  8'h0c
`define SEQ_PID_PRX_DATA   8'h13
`define SEQ_PID_ALM_DATA   8'h1f
`define SEQ_PID_LOG_DATA   8'h86
`define SEQ_PID_DATE_TIME  8'h0e
`define SEQ_PID_POSITION   8'h11
// Command codes carried in command packets and completion packets
`define SEQ_CMD_PRX        16'h0003
`define SEQ_CMD_ALM        16'h0001
`define SEQ_CMD_LOG        16'h005c
`define SEQ_CMD_REQ_TIME   16'h0005
// Fixed almanac table size when entries carry no satellite number
`define SEQ_ALM_SLOTS      16'h0020
// Reset values
`define SEQ_RST_WORD       16'h0000
`define SEQ_RST_PID        8'h00
`endif

// ### rtl/seq_pkg.sv
// Types of the record transfer sequencer.
// Assumes seq_map.svh for the numeric constants.
package seq_pkg;
  typedef enum logic [1:0] {KIND_PRX, KIND_ALM, KIND_LOG} kind_e;
  typedef enum logic [2:0] {ST_IDLE, ST_OPEN, ST_DATA, ST_DONE, ST_REQ, ST_RX} state_e;
  typedef logic [7:0]  pid_t;
  typedef logic [15:0] word_t;
endpackage

// ### rtl/gps_record_transfer_sequencer.sv
// Packet-level sequencer for waypoint, almanac, calendar, flight log and position exchanges.
// Assumes a link layer that frames, checks and acknowledges packets, and a record store
// that supplies the payload for o_tx_index while o_tx_valid is high.
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"

module gps_record_transfer_sequencer
  import seq_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_pid,
  input  wire logic [15:0] i_rx_word,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic [7:0]       o_tx_pid,
  output logic [7:0]       o_tx_byte0,
  output logic [7:0]       o_tx_byte1,
  output logic [15:0]      o_tx_index,
  output logic             o_tx_week_invalid,
  input  wire logic [15:0] i_prx_count,
  input  wire logic [15:0] i_alm_count,
  input  wire logic [15:0] i_log_count,
  input  wire logic        i_alm_has_id,
  input  wire logic [31:0] i_alm_present,
  input  wire logic        i_fix_valid,
  input  wire logic        i_sim_mode,
  output logic             o_rec_store,
  output logic [1:0]       o_rec_kind,
  output logic             o_date_time_load,
  output logic             o_position_load
);

  state_e      state_r, state_nxt;
  kind_e       kind_r, kind_nxt;
  word_t       count_r, count_nxt;
  word_t       idx_r, idx_nxt;
  pid_t        tx_pid_r, tx_pid_nxt;
  word_t       tx_word_r, tx_word_nxt;
  logic        inv_r, inv_nxt;
  logic        store_r, store_nxt;
  logic        dt_r, dt_nxt;
  logic        pos_r, pos_nxt;
  logic        rx_take;
  logic        tx_take;

  // Completion code per transfer kind
  function automatic word_t done_code(input kind_e k);
    case (k)
      KIND_PRX: done_code = `SEQ_CMD_PRX;
      KIND_ALM: done_code = `SEQ_CMD_ALM;
      default:  done_code = `SEQ_CMD_LOG;
    endcase
  endfunction

  // Data packet id per transfer kind
  function automatic pid_t data_pid(input kind_e k);
    case (k)
      KIND_PRX: data_pid = `SEQ_PID_PRX_DATA;
      KIND_ALM: data_pid = `SEQ_PID_ALM_DATA;
      default:  data_pid = `SEQ_PID_LOG_DATA;
    endcase
  endfunction

  // Handshakes; receive is stalled while a transmit sequence runs
  assign o_rx_ready = (state_r == ST_IDLE) || (state_r == ST_RX);
  assign rx_take    = i_rx_valid && o_rx_ready;
  assign o_tx_valid = (state_r == ST_OPEN) || (state_r == ST_DATA) ||
                      (state_r == ST_DONE) || (state_r == ST_REQ);
  assign tx_take    = o_tx_valid && i_tx_ready;

  assign o_tx_byte0        = tx_word_r[7:0];
  assign o_tx_byte1        = tx_word_r[15:8];
  assign o_tx_pid          = tx_pid_r;
  assign o_tx_index        = idx_r;
  assign o_tx_week_invalid = inv_r;
  assign o_rec_store       = store_r;
  assign o_rec_kind        = kind_r;
  assign o_date_time_load  = dt_r;
  assign o_position_load   = pos_r;

  // Sequencer next state
  always_comb
  begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    count_nxt   = count_r;
    idx_nxt     = idx_r;
    tx_pid_nxt  = tx_pid_r;
    tx_word_nxt = tx_word_r;
    inv_nxt     = inv_r;
    store_nxt   = 1'b0;
    dt_nxt      = 1'b0;
    pos_nxt     = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (rx_take)
        begin
          if (i_rx_pid == `SEQ_PID_CMD_DATA)
          begin
            tx_pid_nxt = `SEQ_PID_RECORDS;
            idx_nxt    = `SEQ_RST_WORD;
            if (i_rx_word == `SEQ_CMD_PRX)
            begin
              state_nxt   = ST_OPEN;
              kind_nxt    = KIND_PRX;
              count_nxt   = i_prx_count;
              tx_word_nxt = i_prx_count;
            end
            else if (i_rx_word == `SEQ_CMD_ALM)
            begin
              state_nxt   = ST_OPEN;
              kind_nxt    = KIND_ALM;
              count_nxt   = i_alm_has_id ? i_alm_count : `SEQ_ALM_SLOTS;
              tx_word_nxt = i_alm_has_id ? i_alm_count : `SEQ_ALM_SLOTS;
            end
            else if (i_rx_word == `SEQ_CMD_LOG)
            begin
              state_nxt   = ST_OPEN;
              kind_nxt    = KIND_LOG;
              count_nxt   = i_log_count;
              tx_word_nxt = i_log_count;
            end
          end
          else if (i_rx_pid == `SEQ_PID_RECORDS)
          begin
            state_nxt = ST_RX;
            count_nxt = i_rx_word;
          end
          else if (i_rx_pid == `SEQ_PID_DATE_TIME)
            dt_nxt = 1'b1;
          else if (i_rx_pid == `SEQ_PID_POSITION)
            pos_nxt = !(i_fix_valid || i_sim_mode);
        end
      end
      ST_OPEN:
      begin
        if (tx_take)
        begin
          if (count_r == `SEQ_RST_WORD)
          begin
            state_nxt   = ST_DONE;
            tx_pid_nxt  = `SEQ_PID_XFER_DONE;
            tx_word_nxt = done_code(kind_r);
          end
          else
          begin
            state_nxt   = ST_DATA;
            tx_pid_nxt  = data_pid(kind_r);
            tx_word_nxt = idx_r;
            inv_nxt     = (kind_r == KIND_ALM) && !i_alm_has_id && !i_alm_present[0];
          end
        end
      end
      ST_DATA:
      begin
        if (tx_take)
        begin
          if (idx_r + 16'h0001 == count_r)
          begin
            state_nxt   = ST_DONE;
            tx_pid_nxt  = `SEQ_PID_XFER_DONE;
            tx_word_nxt = done_code(kind_r);
            inv_nxt     = 1'b0;
          end
          else
          begin
            idx_nxt     = idx_r + 16'h0001;
            tx_word_nxt = idx_r + 16'h0001;
            inv_nxt     = (kind_r == KIND_ALM) && !i_alm_has_id &&
                          !i_alm_present[idx_nxt[4:0]];
          end
        end
      end
      ST_DONE,
      ST_REQ:
      begin
        if (tx_take)
        begin
          state_nxt = ST_IDLE;
          idx_nxt   = `SEQ_RST_WORD;
        end
      end
      ST_RX:
      begin
        if (rx_take)
        begin
          if (i_rx_pid == `SEQ_PID_PRX_DATA)
          begin
            store_nxt = 1'b1;
            kind_nxt  = KIND_PRX;
          end
          else if (i_rx_pid == `SEQ_PID_ALM_DATA)
          begin
            store_nxt = 1'b1;
            kind_nxt  = KIND_ALM;
          end
          else if (i_rx_pid == `SEQ_PID_XFER_DONE)
          begin
            if (i_rx_word == `SEQ_CMD_ALM)
            begin
              state_nxt   = ST_REQ;
              tx_pid_nxt  = `SEQ_PID_CMD_DATA;
              tx_word_nxt = `SEQ_CMD_REQ_TIME;
            end
            else
              state_nxt = ST_IDLE;
          end
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r   <= ST_IDLE;
      kind_r    <= KIND_PRX;
      count_r   <= `SEQ_RST_WORD;
      idx_r     <= `SEQ_RST_WORD;
      tx_pid_r  <= `SEQ_RST_PID;
      tx_word_r <= `SEQ_RST_WORD;
      inv_r     <= 1'b0;
      store_r   <= 1'b0;
      dt_r      <= 1'b0;
      pos_r     <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      kind_r    <= kind_nxt;
      count_r   <= count_nxt;
      idx_r     <= idx_nxt;
      tx_pid_r  <= tx_pid_nxt;
      tx_word_r <= tx_word_nxt;
      inv_r     <= inv_nxt;
      store_r   <= store_nxt;
      dt_r      <= dt_nxt;
      pos_r     <= pos_nxt;
    end
  end

  // Checks of the sequencing
  property p_prx_count;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_IDLE && rx_take && i_rx_pid == `SEQ_PID_CMD_DATA &&
     i_rx_word == `SEQ_CMD_PRX) |=> (o_tx_valid && o_tx_pid == `SEQ_PID_RECORDS &&
     tx_word_r == $past(i_prx_count));
  endproperty
  a_prx_count: assert property (p_prx_count) else $error("proximity opener count wrong");

  property p_done_code;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_DONE) |-> (tx_pid_r == `SEQ_PID_XFER_DONE && tx_word_r == done_code(kind_r));
  endproperty
  a_done_code: assert property (p_done_code) else $error("completion code mismatch");

  property p_alm_slots;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_OPEN && kind_r == KIND_ALM && !i_alm_has_id) |-> (count_r == `SEQ_ALM_SLOTS);
  endproperty
  a_alm_slots: assert property (p_alm_slots) else $error("almanac slot count not 32");

  property p_ascend;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_DATA && tx_take && idx_r + 16'h0001 != count_r) |=>
      (state_r == ST_DATA && idx_r == $past(idx_r) + 16'h0001);
  endproperty
  a_ascend: assert property (p_ascend) else $error("data index not ascending");

  property p_invalid;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_DATA && kind_r == KIND_ALM && !i_alm_has_id) |->
      (inv_r == !i_alm_present[idx_r[4:0]]);
  endproperty
  a_invalid: assert property (p_invalid) else $error("week invalid flag wrong");

  property p_req_time;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_RX && rx_take && i_rx_pid == `SEQ_PID_XFER_DONE &&
     i_rx_word == `SEQ_CMD_ALM) |=> (o_tx_valid && tx_word_r == `SEQ_CMD_REQ_TIME);
  endproperty
  a_req_time: assert property (p_req_time) else $error("no time request after almanac");

  property p_pos_drop;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_IDLE && rx_take && i_rx_pid == `SEQ_PID_POSITION) |=>
      (o_position_load == !($past(i_fix_valid) || $past(i_sim_mode)));
  endproperty
  a_pos_drop: assert property (p_pos_drop) else $error("position load gating wrong");

  property p_dt_once;
    @(posedge i_clock) disable iff (i_rst)
    o_date_time_load |-> (state_r == ST_IDLE) ##1 !o_date_time_load;
  endproperty
  a_dt_once: assert property (p_dt_once) else $error("date/time load not single pulse");

  property p_idle_after;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_DONE && tx_take) |=> (state_r == ST_IDLE && o_rx_ready);
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("not idle after completion");

  property p_log_code;
    @(posedge i_clock) disable iff (i_rst)
    (state_r == ST_DONE && kind_r == KIND_LOG) |-> (o_tx_byte0 == 8'h5c && o_tx_byte1 == 8'h00);
  endproperty
  a_log_code: assert property (p_log_code) else $error("log completion bytes wrong");

  c_prx_done: cover property (@(posedge i_clock) state_r == ST_DONE && kind_r == KIND_PRX);
  c_alm_full: cover property (@(posedge i_clock) state_r == ST_DATA && idx_r == 16'h001f);
  c_req_sent: cover property (@(posedge i_clock) state_r == ST_REQ && tx_take);
  c_pos_drop: cover property (@(posedge i_clock) rx_take && i_rx_pid == `SEQ_PID_POSITION &&
                              i_fix_valid);

endmodule // gps_record_transfer_sequencer
`default_nettype wire

// ### tb/host_link_model.sv
// Host side of the link: takes the packets that the sequencer sends.
// Assumes one clock; ready moves only at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
  input  wire logic i_clock,
  input  wire logic i_slow,
  output logic      o_tx_ready
);
  // Prompt acceptance, or random stalls in slow mode
  initial o_tx_ready = 1'b0;
  always @(negedge i_clock)
    o_tx_ready <= i_slow ? 1'($urandom_range(1)) : 1'b1;
endmodule // host_link_model
`default_nettype wire

// ### tb/tb.sv
// Bench of the record transfer sequencer, checked against a queue model.
// Assumes the host link model as transmit partner; inputs move at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module tb
  import seq_pkg::*;
;
  typedef struct packed {logic [7:0] pid; word_t w; word_t ix; logic wi; logic f;} exp_s;
  logic        i_clock = 1'b0, i_rst = 1'b1, i_rx_valid = 1'b0, slow = 1'b0;
  logic        i_alm_has_id = 1'b0, i_fix_valid = 1'b0, i_sim_mode = 1'b0;
  logic [7:0]  i_rx_pid = 8'h00;
  word_t       i_rx_word = 16'h0000, i_prx_count = 16'h0000;
  word_t       i_alm_count = 16'h0000, i_log_count = 16'h0000;
  logic [31:0] i_alm_present = 32'h0000_0000;
  logic        i_tx_ready, o_rx_ready, o_tx_valid, o_tx_week_invalid;
  logic        o_rec_store, o_date_time_load, o_position_load;
  logic [7:0]  o_tx_pid, o_tx_byte0, o_tx_byte1;
  word_t       o_tx_index;
  logic [1:0]  o_rec_kind;
  exp_s        exp_q[$];
  exp_s        cur;
  int          error_cnt = 0;
  int          total_checks = 0;
  // Host gap between incoming waypoints, shortened to keep the run brief
  localparam int prx_gap = 16;

  // Clock at 125 MHz
  always #4 i_clock = ~i_clock;

  gps_record_transfer_sequencer i_gps_record_transfer_sequencer (.i_clock, .i_rst,
    .i_rx_valid, .i_rx_pid, .i_rx_word, .o_rx_ready, .o_tx_valid, .i_tx_ready,
    .o_tx_pid, .o_tx_byte0, .o_tx_byte1, .o_tx_index, .o_tx_week_invalid,
    .i_prx_count, .i_alm_count, .i_log_count, .i_alm_has_id, .i_alm_present,
    .i_fix_valid, .i_sim_mode, .o_rec_store, .o_rec_kind, .o_date_time_load,
    .o_position_load);
  host_link_model i_host_link_model (.i_clock(i_clock), .i_slow(slow), .o_tx_ready(i_tx_ready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One received packet, held until the sequencer takes it
  task automatic send(input logic [7:0] pid, input word_t w);
    int n;
    n = 0;
    @(negedge i_clock);
    i_rx_pid = pid;
    i_rx_word = w;
    i_rx_valid = 1'b1;
    while (o_rx_ready !== 1'b1 && n < 200)
    begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 200)
      error_cnt++;
    @(negedge i_clock);
    i_rx_valid = 1'b0;
  endtask

  // Model of an outgoing transfer: opener, records, completion
  function automatic void push(input logic [7:0] p, input word_t w, input word_t ix,
                               input logic wi, input logic f);
    exp_q.push_back('{p, w, ix, wi, f});
  endfunction
  function automatic void expect_xfer(input logic [7:0] dp, input word_t cmd, input int cnt,
                                      input logic noid);
    push(`SEQ_PID_RECORDS, 16'(cnt), 16'h0000, 1'b0, 1'b0);
    for (int k = 0; k < cnt; k++)
      push(dp, 16'(k), 16'(k), noid & ~i_alm_present[k], 1'b1);
    push(`SEQ_PID_XFER_DONE, cmd, 16'h0000, 1'b0, 1'b0);
  endfunction

  // Waits until the modelled packets have all gone out
  task automatic drain();
    int n;
    n = 0;
    chk(o_rx_ready, 1'b0);
    while ((exp_q.size() != 0 || o_tx_valid !== 1'b0) && n < 1000)
    begin
      @(negedge i_clock);
      n++;
    end
    chk(32'(exp_q.size()), 32'h0000_0000);
    chk(o_rx_ready, 1'b1);
  endtask

  // Each accepted packet is compared with the head of the model
  always @(posedge i_clock)
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'(o_tx_pid), 32'h0000_0100);
      else
      begin
        cur = exp_q.pop_front();
        chk(o_tx_pid, cur.pid);
        chk({o_tx_byte1, o_tx_byte0}, cur.w);
        if (cur.f)
        begin
          chk(o_tx_index, cur.ix);
          chk(o_tx_week_invalid, cur.wi);
        end
      end
    end

  // Main sequence
  initial
  begin
    void'($urandom(32'h6e52));
    repeat (4) @(posedge i_clock);
    chk(o_rx_ready, 1'b1);
    chk(o_tx_valid, 1'b0);
    @(negedge i_clock);
    i_rst = 1'b0;
    for (int r = 0; r < 6; r++)
    begin
      slow = r[0];
      i_prx_count = 16'($urandom_range(3));
      i_log_count = 16'($urandom_range(4, 1));
      i_alm_count = 16'($urandom_range(3, 1));
      i_alm_has_id = (r > 3);
      i_alm_present = $urandom();
      case (r % 3)
        0: expect_xfer(`SEQ_PID_PRX_DATA, `SEQ_CMD_PRX, i_prx_count, 1'b0);
        1: expect_xfer(`SEQ_PID_ALM_DATA, `SEQ_CMD_ALM, i_alm_has_id ? i_alm_count : 32,
                       ~i_alm_has_id);
        default: expect_xfer(`SEQ_PID_LOG_DATA, 16'h005c, i_log_count, 1'b0);
      endcase
      send(`SEQ_PID_CMD_DATA, r % 3 == 0 ? `SEQ_CMD_PRX :
           r % 3 == 1 ? `SEQ_CMD_ALM : `SEQ_CMD_LOG);
      drain();
    end
    send(`SEQ_PID_DATE_TIME, 16'($urandom()));
    chk(o_date_time_load, 1'b1);
    @(negedge i_clock);
    chk(o_date_time_load, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      i_fix_valid = m[0];
      i_sim_mode = m[1];
      send(`SEQ_PID_POSITION, 16'($urandom()));
      chk(o_position_load, m == 0);
    end
    i_fix_valid = 1'b0;
    i_sim_mode = 1'b0;
    // incoming partial set, then almanac with time request
    for (int t = 0; t < 2; t++)
    begin
      send(`SEQ_PID_RECORDS, 16'h0005);
      for (int d = 0; d < 2; d++)
      begin
        if (t == 0)
          repeat (prx_gap) @(negedge i_clock);
        send(t ? `SEQ_PID_ALM_DATA : `SEQ_PID_PRX_DATA, 16'($urandom()));
        chk(o_rec_store, 1'b1);
        chk(o_rec_kind, t ? KIND_ALM : KIND_PRX);
      end
      send(`SEQ_PID_DATE_TIME, 16'h0000);
      chk(o_date_time_load, 1'b0);
      if (t)
        push(`SEQ_PID_CMD_DATA, `SEQ_CMD_REQ_TIME, 16'h0000, 1'b0, 1'b0);
      send(`SEQ_PID_XFER_DONE, t ? `SEQ_CMD_ALM : `SEQ_CMD_PRX);
      if (t)
        drain();
      send(`SEQ_PID_DATE_TIME, 16'h0000);
      chk(o_date_time_load, 1'b1);
      send(`SEQ_PID_POSITION, 16'h0000);
      chk(o_position_load, 1'b1);
    end
    close_out();
  end

  // Cuts a hang short
  initial
  begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule // tb
`default_nettype wire
